// ---- rtl/pp_pkg.sv ----
// Shared constants for the pack protection controller.
package pp_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h01;
	localparam logic [7:0] ADDR_CONTROL = 8'h02;
	localparam logic [7:0] ADDR_DIS_SET = 8'h05;
	localparam logic [7:0] ADDR_CHG_SET = 8'h06;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_DIS_SET = 8'h00;
	localparam logic [7:0] RST_CHG_SET = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int ST_DOC = 0;
	localparam int ST_DSC = 1;
	localparam int ST_COC = 2;
	localparam int ST_IOT = 3;
	localparam int ST_XOT = 4;
	localparam int ST_LOAD_PRESENT_STATUS = 5;
	localparam int ST_OTHOLD = 6;
	localparam int CF_DIS_OCD = 0;
	localparam int CF_DIS_SCD = 1;
	localparam int CF_DIS_OCC = 2;
	localparam int CF_DIS_ITSD = 3;
	localparam int CF_DIS_XTSD = 4;
	localparam int CF_SCAN_OFF = 5;
	localparam int CF_FORCE_ON = 6;
	localparam int CT_DISCHARGE_GATE_DRIVE = 0;
	localparam int CT_CHARGE_GATE_DRIVE = 1;
	localparam int CT_LDMON = 2;
	localparam int CT_AO_LSB = 4;
	localparam int DS_OCD_DLY_LSB = 0;
	localparam int DS_SCD_DLY = 3;
	localparam int DS_SCD_THR_LSB = 4;
	localparam int DS_OCD_THR_LSB = 6;
	localparam int CS_SCALE = 2;
	localparam int CS_OCC_DLY_LSB = 3;
	localparam int CS_OCC_THR_LSB = 6;
	localparam logic [3:0] AO_EXT_TEMP = 4'hF;
	localparam logic [2:0] ST_CLR_MASK = 3'h7;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MS_PS = 1000000000;
	localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
	localparam int SETTLE_MS = 1;
	localparam int SCAN_ON_MS = 5;
	localparam int SCAN_PERIOD_MS = 640;
	localparam int DELAY_UNIT_NS = 1000;
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS * 1000 / CLK_PERIOD_PS;
	localparam int SCALE_SHIFT = 3;
	localparam int LIM_W = 8;
	localparam int NFAULT = 3;
endpackage : pp_pkg

// ---- rtl/pp_sync.sv ----
// Two-stage synchroniser for comparator levels.
`timescale 1ns/1ps
module pp_sync #(
	parameter int WIDTH = 6
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] out_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			out_q <= '0;
		end else if (ce) begin
			meta_q <= din;
			out_q <= meta_q;
		end
	end

	assign dout = out_q;
endmodule : pp_sync

// ---- rtl/pp_fault_timer.sv ----
// Qualifies a fault condition that must persist for a selected delay.
`timescale 1ns/1ps
module pp_fault_timer #(
	parameter int LW = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic cond,
	input wire logic [LW-1:0] limit,
	output logic fire
);
	logic [LW-1:0] cnt_q, cnt_d;
	logic done_q, done_d;
	logic fire_q, fire_d;

	// The first tick may come early, so firing waits for one tick past the limit.
	always_comb begin
		cnt_d = cnt_q;
		done_d = done_q;
		fire_d = 1'b0;
		if (!cond) begin
			cnt_d = '0;
			done_d = 1'b0;
		end else if (tick && !done_q) begin
			if (cnt_q == limit) begin
				fire_d = 1'b1;
				done_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			done_q <= 1'b0;
			fire_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			done_q <= done_d;
			fire_q <= fire_d;
		end
	end

	assign fire = fire_q;
endmodule : pp_fault_timer

// ---- rtl/pp_protect.sv ----
// Pack protection controller: current faults, temperature scan and switch control.
// Overview of operation
// - Current above threshold longer than delay enters protection, both gate drives off.
// - Thresholds and delays come from registers 05h and 06h.
// - Discharge drive pulled low actively; charge drive released to external resistor.
// - Discharge overcurrent turns switches off and sets its flag.
// - Automatic switch-off also clears both switch control bits.
// - Each current fault has its own disable bit for automatic response.
// - Short circuit turns switches off and sets its flag.
// - Charge overcurrent turns switches off and sets its flag.
// - With response disabled the flag still sets; switches stay on for the host to turn off.
// - Any current fault flag drives sensor supply high as a wake line.
// - Load monitor switch on only while its enable bit is set.
// - Load-fail status clears once load sense shows load removed.
// - Auto-scan disable bit stops the periodic scan.
// - After supply settles, thermistor below reference flags external overtemperature.
// - Selecting external temperature on analog output holds supply on.
// - Force-on bit keeps supply on continuously.
// - Overtemperature turns switches off, blocks balancing, sets its flag.
// - During overtemperature hold, switch control writes are ignored.
// - Separate disable bits suppress internal and external overtemperature response.
`timescale 1ns/1ps
module pp_protect #(
	parameter int MS_CYCLES = pp_pkg::MS_CYCLES,
	parameter int UNIT_CYCLES = pp_pkg::DELAY_UNIT_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic oc_dis_cmp,
	input wire logic sc_cmp,
	input wire logic oc_chg_cmp,
	input wire logic int_hot_cmp,
	input wire logic therm_low_cmp,
	input wire logic load_sense_cmp,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	output logic discharge_gate_drive,
	output logic discharge_gate_pulldown,
	output logic charge_gate_drive,
	output logic sensor_supply_output,
	output logic load_monitor_switch,
	output logic cell_balance_block,
	output logic [1:0] oc_dis_thr_sel,
	output logic [1:0] sc_thr_sel,
	output logic [1:0] oc_chg_thr_sel,
	output logic [3:0] analog_select_field
);
	localparam int SETTLE_CYC = pp_pkg::SETTLE_MS * MS_CYCLES;
	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam int UW = $clog2(UNIT_CYCLES + 1);
	localparam int SW = $clog2(SETTLE_CYC + 1);
	localparam int PW = $clog2(pp_pkg::SCAN_PERIOD_MS + 1);
	localparam int LW = pp_pkg::LIM_W;

	generate
		if (MS_CYCLES < 2 || UNIT_CYCLES < 2) begin : g_bad
			$error("Prescaler counts must be at least two cycles");
		end
	endgenerate

	// ****************************************
	// Reset release and input synchronisers
	// ****************************************
	logic rst_meta_q, rst_n_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	logic oc_dis_s, sc_s, oc_chg_s, int_hot_s, therm_low_s, load_sense_s;
	pp_sync #(.WIDTH(6)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n_q),
		.ce(ce),
		.din({oc_dis_cmp, sc_cmp, oc_chg_cmp, int_hot_cmp, therm_low_cmp, load_sense_cmp}),
		.dout({oc_dis_s, sc_s, oc_chg_s, int_hot_s, therm_low_s, load_sense_s})
	);

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] status_q, status_d;
	logic [7:0] config_q, config_d;
	logic [7:0] control_q, control_d;
	logic [7:0] dis_set_q, dis_set_d;
	logic [7:0] chg_set_q, chg_set_d;
	logic [7:0] rdata_q, rdata_d;
	logic xot_cond_q, xot_cond_d;
	logic ot_hold_q, ot_hold_d;
	logic supply_q, supply_d;

	// ****************************************
	// Prescalers and temperature scan timing
	// ****************************************
	logic [MSW-1:0] ms_cnt_q, ms_cnt_d;
	logic [UW-1:0] us_cnt_q, us_cnt_d;
	logic [PW-1:0] per_q, per_d;
	logic [SW-1:0] settle_q, settle_d;
	logic ms_tick, unit_tick, scan_win, measure;

	always_comb begin
		ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
		unit_tick = (us_cnt_q == UW'(UNIT_CYCLES - 1));
		ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 1'b1;
		us_cnt_d = unit_tick ? '0 : us_cnt_q + 1'b1;
		per_d = per_q;
		if (ms_tick) begin
			per_d = (per_q == PW'(pp_pkg::SCAN_PERIOD_MS - 1)) ? '0 : per_q + 1'b1;
		end
		scan_win = !config_q[pp_pkg::CF_SCAN_OFF] && (per_q < PW'(pp_pkg::SCAN_ON_MS));
		// Settling counts whole cycles so the wait never falls short of the full time.
		settle_d = settle_q;
		if (!supply_q) begin
			settle_d = '0;
		end else if (settle_q != SW'(SETTLE_CYC)) begin
			settle_d = settle_q + 1'b1;
		end
		measure = supply_q && (settle_q == SW'(SETTLE_CYC));
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ms_cnt_q <= '0;
			us_cnt_q <= '0;
			per_q <= '0;
			settle_q <= '0;
		end else if (ce) begin
			ms_cnt_q <= ms_cnt_d;
			us_cnt_q <= us_cnt_d;
			per_q <= per_d;
			settle_q <= settle_d;
		end
	end

	// ****************************************
	// Current fault qualification
	// ****************************************
	logic [pp_pkg::NFAULT-1:0] fcond, fire;
	logic [LW-1:0] flim [pp_pkg::NFAULT];
	logic [LW-1:0] scale_sh;

	always_comb begin
		scale_sh = chg_set_q[pp_pkg::CS_SCALE] ? LW'(pp_pkg::SCALE_SHIFT) : '0;
		fcond = {oc_chg_s, sc_s, oc_dis_s};
		flim[0] = (LW'(dis_set_q[pp_pkg::DS_OCD_DLY_LSB +: 3]) + 1'b1) << scale_sh;
		flim[1] = (LW'(dis_set_q[pp_pkg::DS_SCD_DLY]) + 1'b1) << scale_sh;
		flim[2] = (LW'(chg_set_q[pp_pkg::CS_OCC_DLY_LSB +: 3]) + 1'b1) << scale_sh;
	end

	generate
		for (genvar i = 0; i < pp_pkg::NFAULT; i++) begin : g_fault
			pp_fault_timer #(.LW(LW)) u_timer (
				.mclk(mclk),
				.rst_n(rst_n_q),
				.ce(ce),
				.tick(unit_tick),
				.cond(fcond[i]),
				.limit(flim[i]),
				.fire(fire[i])
			);
		end
	endgenerate

	// ****************************************
	// Protection, flags and register access
	// ****************************************
	logic [pp_pkg::NFAULT-1:0] fault_en;
	logic auto_off, wr_status, wr_ctrl, oc_flag_any;
	logic [7:0] set_bits, clr_bits;

	always_comb begin
		fault_en = ~{config_q[pp_pkg::CF_DIS_OCC], config_q[pp_pkg::CF_DIS_SCD],
			config_q[pp_pkg::CF_DIS_OCD]};
		ot_hold_d = (int_hot_s && !config_q[pp_pkg::CF_DIS_ITSD])
			|| (xot_cond_q && !config_q[pp_pkg::CF_DIS_XTSD]);
		auto_off = |(fire & fault_en) || ot_hold_q;
		wr_status = reg_we && (reg_addr == pp_pkg::ADDR_STATUS);
		wr_ctrl = reg_we && (reg_addr == pp_pkg::ADDR_CONTROL);
		xot_cond_d = measure ? therm_low_s : xot_cond_q;
		set_bits = '0;
		set_bits[pp_pkg::ST_DOC] = fire[0];
		set_bits[pp_pkg::ST_DSC] = fire[1];
		set_bits[pp_pkg::ST_COC] = fire[2];
		set_bits[pp_pkg::ST_IOT] = int_hot_s;
		set_bits[pp_pkg::ST_XOT] = measure && therm_low_s;
		clr_bits = '0;
		if (wr_status) begin
			clr_bits[pp_pkg::ST_XOT:pp_pkg::ST_DOC] = reg_wdata[pp_pkg::ST_XOT:pp_pkg::ST_DOC];
		end
		// A fault arriving with its clear keeps the flag set.
		status_d = (status_q & ~clr_bits) | set_bits;
		if (control_q[pp_pkg::CT_LDMON]) begin
			status_d[pp_pkg::ST_LOAD_PRESENT_STATUS] = load_sense_s;
		end
		status_d[pp_pkg::ST_OTHOLD] = ot_hold_q;
		status_d[7] = 1'b0;
		config_d = config_q;
		dis_set_d = dis_set_q;
		chg_set_d = chg_set_q;
		control_d = control_q;
		if (reg_we && reg_addr == pp_pkg::ADDR_CONFIG) begin
			config_d = {1'b0, reg_wdata[6:0]};
		end
		if (reg_we && reg_addr == pp_pkg::ADDR_DIS_SET) begin
			dis_set_d = reg_wdata;
		end
		if (reg_we && reg_addr == pp_pkg::ADDR_CHG_SET) begin
			chg_set_d = reg_wdata;
		end
		if (wr_ctrl) begin
			control_d = {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
			if (ot_hold_q) begin
				control_d[pp_pkg::CT_CHARGE_GATE_DRIVE:pp_pkg::CT_DISCHARGE_GATE_DRIVE]
					= control_q[pp_pkg::CT_CHARGE_GATE_DRIVE:pp_pkg::CT_DISCHARGE_GATE_DRIVE];
			end
		end
		// Automatic switch-off overrides a simultaneous write to the switch bits.
		if (auto_off) begin
			control_d[pp_pkg::CT_DISCHARGE_GATE_DRIVE] = 1'b0;
			control_d[pp_pkg::CT_CHARGE_GATE_DRIVE] = 1'b0;
		end
		oc_flag_any = |status_q[pp_pkg::ST_COC:pp_pkg::ST_DOC];
		supply_d = config_q[pp_pkg::CF_FORCE_ON]
			|| (control_q[pp_pkg::CT_AO_LSB +: 4] == pp_pkg::AO_EXT_TEMP)
			|| scan_win
			|| oc_flag_any;
		rdata_d = rdata_q;
		if (reg_re) begin
			case (reg_addr)
				pp_pkg::ADDR_STATUS: rdata_d = status_q;
				pp_pkg::ADDR_CONFIG: rdata_d = config_q;
				pp_pkg::ADDR_CONTROL: rdata_d = control_q;
				pp_pkg::ADDR_DIS_SET: rdata_d = dis_set_q;
				pp_pkg::ADDR_CHG_SET: rdata_d = chg_set_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_q <= pp_pkg::RST_STATUS;
			config_q <= pp_pkg::RST_CONFIG;
			control_q <= pp_pkg::RST_CONTROL;
			dis_set_q <= pp_pkg::RST_DIS_SET;
			chg_set_q <= pp_pkg::RST_CHG_SET;
			rdata_q <= 8'h00;
			xot_cond_q <= 1'b0;
			ot_hold_q <= 1'b0;
			supply_q <= 1'b0;
		end else if (ce) begin
			status_q <= status_d;
			config_q <= config_d;
			control_q <= control_d;
			dis_set_q <= dis_set_d;
			chg_set_q <= chg_set_d;
			rdata_q <= rdata_d;
			xot_cond_q <= xot_cond_d;
			ot_hold_q <= ot_hold_d;
			supply_q <= supply_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The gate drives follow the control bits, so clearing the bits is the switch-off.
	assign discharge_gate_drive = control_q[pp_pkg::CT_DISCHARGE_GATE_DRIVE];
	assign discharge_gate_pulldown = !control_q[pp_pkg::CT_DISCHARGE_GATE_DRIVE];
	assign charge_gate_drive = control_q[pp_pkg::CT_CHARGE_GATE_DRIVE];
	assign sensor_supply_output = supply_q;
	assign load_monitor_switch = control_q[pp_pkg::CT_LDMON];
	assign cell_balance_block = ot_hold_q;
	assign oc_dis_thr_sel = dis_set_q[pp_pkg::DS_OCD_THR_LSB +: 2];
	assign sc_thr_sel = dis_set_q[pp_pkg::DS_SCD_THR_LSB +: 2];
	assign oc_chg_thr_sel = chg_set_q[pp_pkg::CS_OCC_THR_LSB +: 2];
	assign analog_select_field = control_q[pp_pkg::CT_AO_LSB +: 4];
	assign reg_rdata = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n_q);

	sequence s_oc_trip;
		ce && fire[0] && fault_en[0];
	endsequence
	sequence s_gates_off;
		!discharge_gate_drive && !charge_gate_drive && discharge_gate_pulldown;
	endsequence

	chk_oc_gates_off: assert property (s_oc_trip |=> s_gates_off)
		else $error("Switches stayed on after discharge overcurrent");
	chk_sc_flag_set: assert property (ce && fire[1] |=> status_q[pp_pkg::ST_DSC])
		else $error("Short-circuit flag not set");
	chk_coc_off: assert property (ce && fire[2] && fault_en[2] |=> s_gates_off)
		else $error("Switches stayed on after charge overcurrent");
	chk_disabled_no_act: assert property (ce && fire[0] && !fault_en[0] && !ot_hold_q
		&& !fire[1] && !fire[2] && !wr_ctrl && discharge_gate_drive
		|=> discharge_gate_drive && status_q[pp_pkg::ST_DOC])
		else $error("Disabled response acted or flag missing");
	chk_wake_supply: assert property (ce && oc_flag_any |=> sensor_supply_output)
		else $error("Supply not raised by current fault flag");
	chk_force_supply: assert property (ce && config_q[pp_pkg::CF_FORCE_ON]
		|=> sensor_supply_output)
		else $error("Force-on did not hold supply");
	chk_settle_wait: assert property (ce && $rose(status_q[pp_pkg::ST_XOT])
		|-> $past(settle_q) == SW'(SETTLE_CYC) && $past(supply_q))
		else $error("External overtemperature flagged before settling");
	chk_ot_ignore_wr: assert property (ce && ot_hold_q && wr_ctrl && !discharge_gate_drive
		|=> !discharge_gate_drive)
		else $error("Switch write accepted during overtemperature hold");
	chk_flag_sticky: assert property (ce && status_q[pp_pkg::ST_COC] && !wr_status
		|=> status_q[pp_pkg::ST_COC])
		else $error("Fault flag cleared without a write");
endmodule : pp_protect

// ---- sim/pp_host_model.sv ----
// Microcontroller model that drives the register port of the controller.
`timescale 1ns/1ps
module pp_host_model (
	input wire logic mclk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
	end
	// ****
	// Transfers
	// ****
	// Only this model starts transfers; the idle address, and after a write the data, show the inverse value.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge mclk);
		reg_we <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		// Callers look at outputs at once, so let the registers settle first.
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge mclk);
		reg_re <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : pp_host_model

// ---- sim/tb_pp_protect.sv ----
// Self-checking bench for the pack protection controller.
`timescale 1ns/1ps
module tb_pp_protect;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] cc = 3'h0;
	logic hot = 1'b0;
	logic tlow = 1'b0;
	logic lsen = 1'b0;
	logic ce = 1'b1;
	logic [7:0] addr, wdata, rdata, v, r;
	logic we, re, dg, dpd, cg, sup, lms, cbb;
	logic [1:0] t0, t1, t2;
	logic [3:0] aos;
	int err_total = 0;
	int num_checks = 0;
	int n, d, lim;
	always #2.5 mclk = ~mclk;
	pp_protect #(.MS_CYCLES(20), .UNIT_CYCLES(4)) uut (.mclk(mclk), .arst_n(arst_n),
		.ce(ce), .oc_dis_cmp(cc[0]), .sc_cmp(cc[1]), .oc_chg_cmp(cc[2]),
		.int_hot_cmp(hot), .therm_low_cmp(tlow), .load_sense_cmp(lsen),
		.reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_re(re),
		.reg_rdata(rdata), .discharge_gate_drive(dg), .discharge_gate_pulldown(dpd),
		.charge_gate_drive(cg), .sensor_supply_output(sup), .load_monitor_switch(lms),
		.cell_balance_block(cbb), .oc_dis_thr_sel(t0), .sc_thr_sel(t1),
		.oc_chg_thr_sel(t2), .analog_select_field(aos));
	pp_host_model host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata),
		.reg_we(we), .reg_re(re), .reg_rdata(rdata));
	// ****
	// Helpers
	// ****
	// Delay bounds allow for the partial first tick and the input synchroniser.
	function automatic int dmin(input int lim_ticks);
		return lim_ticks * 4;
	endfunction : dmin
	function automatic int dmax(input int lim_ticks);
		return lim_ticks * 4 + 16;
	endfunction : dmax
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] k, input logic [7:0] e);
		host.rd(a, r);
		chk(r & k, e, "register read");
	endtask : rdc
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic wt(input logic s, input logic l, input int lim, output int c);
		c = 0;
		while ((s ? sup : dg) !== l && c < lim) begin
			@(posedge mclk);
			#1;
			c++;
		end
	endtask : wt
	task automatic ok(input logic b, input string m);
		chk({7'h00, b}, 8'h01, m);
	endtask : ok
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (80000) @(posedge mclk);
		err_total++;
		print_verdict();
	end
	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(88793));
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		cyc(4);
		ok(dpd === 1'b1 && dg === 1'b0, "gates at reset");
		for (int a = 0; a < 8; a++) rdc(8'(a), 8'hFF, 8'h00);
		v = 8'($urandom);
		host.wr(pp_pkg::ADDR_DIS_SET, v);
		rdc(pp_pkg::ADDR_DIS_SET, 8'hFF, v);
		ok(t0 === v[7:6] && t1 === v[5:4], "threshold select");
		host.wr(pp_pkg::ADDR_CHG_SET, v);
		rdc(pp_pkg::ADDR_CHG_SET, 8'hFC, v & 8'hFC);
		ok(t2 === v[7:6], "charge threshold");
		host.wr(8'h03, 8'hFF);
		rdc(8'h03, 8'hFF, 8'h00);
		$display("test registers done");
		for (int k = 0; k < 3; k++) begin
			d = $urandom_range(7);
			host.wr(pp_pkg::ADDR_DIS_SET, {4'h0, 1'(d), 3'(d)});
			lim = (k == 1) ? d % 2 + 1 : d + 1;
			if (k == 2) lim = lim << pp_pkg::SCALE_SHIFT;
			host.wr(pp_pkg::ADDR_CHG_SET, {2'h0, 3'(d), 1'(k == 2), 2'h0});
			for (int s = 0; s < 2; s++) begin
				host.wr(pp_pkg::ADDR_CONFIG, 8'h20 | (8'(s) << k));
				host.wr(pp_pkg::ADDR_CONTROL, 8'h03);
				ok(dg === 1'b1 && cg === 1'b1 && dpd === 1'b0, "gates on");
				@(posedge mclk);
				cc[k] <= 1'b1;
				if (s == 0) begin
					wt(1'b0, 1'b0, 400, n);
					ok(n < 400 && n >= dmin(lim) && n <= dmax(lim), "delay");
					ok(dpd === 1'b1 && cg === 1'b0, "gates off");
					rdc(pp_pkg::ADDR_CONTROL, 8'h03, 8'h00);
					ok(sup === 1'b1, "wake line");
				end else begin
					cyc(400);
					ok(dg === 1'b1, "response disabled");
				end
				rdc(pp_pkg::ADDR_STATUS, 8'h07, 8'h01 << k);
				@(posedge mclk);
				cc[k] <= 1'b0;
				cyc(20);
				rdc(pp_pkg::ADDR_STATUS, 8'h07, 8'h01 << k);
				host.wr(pp_pkg::ADDR_STATUS, 8'h01 << k);
				rdc(pp_pkg::ADDR_STATUS, 8'h07, 8'h00);
				host.wr(pp_pkg::ADDR_CONTROL, 8'h00);
			end
		end
		$display("test current faults done");
		for (int s = 0; s < 2; s++) begin
			host.wr(pp_pkg::ADDR_CONFIG, s ? 8'h28 : 8'h20);
			host.wr(pp_pkg::ADDR_CONTROL, 8'h03);
			@(posedge mclk);
			hot <= 1'b1;
			cyc(12);
			ok(dg === 1'(s) && cbb === 1'(!s), "overtemp response");
			rdc(pp_pkg::ADDR_STATUS, 8'h48, s ? 8'h08 : 8'h48);
			host.wr(pp_pkg::ADDR_CONTROL, 8'h03);
			ok(dg === 1'(s), "write during hold");
			@(posedge mclk);
			hot <= 1'b0;
			cyc(10);
			host.wr(pp_pkg::ADDR_STATUS, 8'h08);
			host.wr(pp_pkg::ADDR_CONTROL, 8'h03);
			ok(dg === 1'b1, "re-enable");
		end
		@(posedge mclk);
		tlow <= 1'b1;
		host.wr(pp_pkg::ADDR_CONFIG, 8'h60);
		cyc(3);
		ok(sup === 1'b1, "force on");
		cyc(40);
		rdc(pp_pkg::ADDR_STATUS, 8'h10, 8'h10);
		ok(dg === 1'b0, "external overtemp");
		@(posedge mclk);
		tlow <= 1'b0;
		cyc(40);
		host.wr(pp_pkg::ADDR_STATUS, 8'h10);
		host.wr(pp_pkg::ADDR_CONFIG, 8'h20);
		host.wr(pp_pkg::ADDR_CONTROL, 8'h00);
		cyc(3);
		ok(sup === 1'b0, "scan off");
		host.wr(pp_pkg::ADDR_CONTROL, {pp_pkg::AO_EXT_TEMP, 4'h0});
		cyc(3);
		ok(sup === 1'b1, "analog select");
		ok(aos === pp_pkg::AO_EXT_TEMP, "analog select field");
		host.wr(pp_pkg::ADDR_CONTROL, 8'h04);
		ok(lms === 1'b1, "load monitor on");
		@(posedge mclk);
		lsen <= 1'b1;
		cyc(6);
		rdc(pp_pkg::ADDR_STATUS, 8'h20, 8'h20);
		@(posedge mclk);
		lsen <= 1'b0;
		cyc(6);
		rdc(pp_pkg::ADDR_STATUS, 8'h20, 8'h00);
		host.wr(pp_pkg::ADDR_CONTROL, 8'h00);
		ok(lms === 1'b0, "load monitor off");
		@(posedge mclk);
		ce <= 1'b0;
		host.wr(pp_pkg::ADDR_CONTROL, 8'h03);
		ok(dg === 1'b0, "frozen by clock enable");
		@(posedge mclk);
		ce <= 1'b1;
		$display("test temperature and load done");
		host.wr(pp_pkg::ADDR_CONFIG, 8'h00);
		wt(1'b1, 1'b1, 13000, n);
		wt(1'b1, 1'b0, 13000, n);
		wt(1'b1, 1'b1, 13000, n);
		ok(n >= 12698 && n <= 12702, "scan off time");
		wt(1'b1, 1'b0, 13000, n);
		ok(n >= 98 && n <= 102, "scan on time");
		$display("test scan done");
		print_verdict();
	end
endmodule : tb_pp_protect
